// file: hdl/adc_serial_conversion_control.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_serial_conversion_control #(
  parameter bit TEN_BIT = 1'b0,
  parameter int NUM_CHAN = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // conversion pins
  input wire logic conversion_start_n_i,
  output logic end_of_conversion_n_o,
  // converter core
  input wire adc_ctrl_pkg::sample_t sample_i,
  output logic [3:0] mux_chan_o,
  output logic sample_o,
  // status
  output logic internal_clock_o,
  output logic channel_tag_enable_o,
  output logic software_convert_trigger_o,
  output logic pseudo_diff_common_select_o,
  output logic fifo_empty_o
);
  logic sclk_s, cs_n_s, sdi_s, cnv_n_s;
  logic sclk_d, cs_d, cnv_d;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cnv_fall, cnv_rise;
  adc_sync2 u_sync_sclk (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(sclk_i), .q_o(sclk_s));
  adc_sync2 u_sync_cs (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(cs_n_i), .q_o(cs_n_s));
  adc_sync2 u_sync_sdi (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(sdi_i), .q_o(sdi_s));
  adc_sync2 u_sync_cnv (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(conversion_start_n_i), .q_o(cnv_n_s));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
      cnv_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_n_s;
      cnv_d <= cnv_n_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d && !cs_n_s;
  assign cs_fall = !cs_n_s && cs_d;
  assign cs_rise = cs_n_s && !cs_d;
  assign cnv_fall = !cnv_n_s && cnv_d;
  assign cnv_rise = cnv_n_s && !cnv_d;

  // conversion arithmetic: clamp, coding and resolution
  function automatic logic [11:0] encode(input adc_ctrl_pkg::sample_t s, input logic uni_cfg);
    logic [11:0] c;
    logic uni;
    c = '0;
    uni = s.single_ended || uni_cfg || !s.bipolar; // [RULE9]
    if (uni) begin
      if (s.diff < 0) begin
        c = '0; // [RULE8]
      end else if (s.diff > 13'sh0FFF) begin
        c = 12'hFFF;
      end else begin
        c = s.diff[11:0]; // [RULE11]
      end
    end else begin
      if (s.diff > 13'sh07FF) begin
        c = 12'h7FF;
      end else if (s.diff < -13'sh0800) begin
        c = 12'h800;
      end else begin
        c = s.diff[11:0]; // [RULE11]
      end
    end
    if (TEN_BIT) begin
      c[1:0] = 2'h0; // [RULE7]
    end
    return c;
  endfunction

  // frame shift registers
  logic [`WORD_BITS-1:0] rx_shift;
  logic [`WORD_BITS-1:0] tx_shift;
  logic [5:0] bit_cnt;
  logic in_frame;
  logic word_done;
  assign word_done = sclk_rise && (bit_cnt == 6'(`WORD_BITS - 1));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_shift <= '0;
      bit_cnt <= '0;
      in_frame <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt <= '0; // [RULE3]
      in_frame <= 1'b1;
    end else if (cs_rise) begin
      in_frame <= 1'b0;
    end else if (sclk_rise && in_frame) begin
      rx_shift <= {rx_shift[`WORD_BITS-2:0], sdi_s}; // [RULE2]
      if (bit_cnt != 6'(`WORD_BITS - 1)) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end

  // configuration bits written through the serial frame
  logic [`WORD_BITS-1:0] rx_word;
  logic mode_wr, uni_wr;
  logic unipolar_all;
  logic [3:0] scan_mode;
  logic soft_reset;
  logic [3:0] chan_sel;
  assign rx_word = {rx_shift[`WORD_BITS-2:0], sdi_s};
  assign mode_wr = word_done && in_frame && !rx_word[`REG_SEL_BIT]; // [RULE23]
  assign uni_wr = word_done && in_frame && rx_word[`REG_SEL_BIT]
    && (rx_word[`CFG_ID_HI:`CFG_ID_LO] == `CFG_ID_UNI); // [RULE23]
  assign soft_reset = word_done && in_frame && rx_word[`REG_SEL_BIT]
    && (rx_word[`CFG_ID_HI:`CFG_ID_LO] == `CFG_ID_ADC)
    && (rx_word[`RESET_HI:`RESET_LO] == `SOFT_RESET); // [RULE22]
  assign unipolar_all = pseudo_diff_common_select_o;
  assign internal_clock_o = (scan_mode != `SCAN_MANUAL);

  logic conv_done;
  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset) begin
      scan_mode <= `SCAN_MANUAL;
      chan_sel <= '0;
      channel_tag_enable_o <= 1'b0;
    end else if (mode_wr) begin
      scan_mode <= rx_word[`SCAN_HI:`SCAN_LO];
      chan_sel <= rx_word[`CHSEL_HI:`CHSEL_LO]; // [RULE16]
      channel_tag_enable_o <= rx_word[`CHAN_TAG_BIT];
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset) begin
      software_convert_trigger_o <= 1'b0;
    end else if (mode_wr) begin
      software_convert_trigger_o <= rx_word[`SOFTWARE_CONVERT_TRIGGER_BIT];
    end else if (conv_done) begin
      software_convert_trigger_o <= 1'b0; // [RULE21]
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset) begin
      pseudo_diff_common_select_o <= 1'b0;
    end else if (uni_wr) begin
      pseudo_diff_common_select_o <= rx_word[`PDIFF_BIT]; // [RULE10]
    end
  end

  // write frames shorter than the minimum do not start the software trigger conversion at chip select rise
  logic [5:0] cs_low_cnt;
  always_ff @(posedge mclk_i) begin
    if (reset_i || cs_fall) begin
      cs_low_cnt <= '0;
    end else if (!cs_n_s && cs_low_cnt != 6'(`WRITE_MIN_CLOCKS)) begin
      cs_low_cnt <= cs_low_cnt + 1'b1;
    end
  end

  // internal clock scan sequencer
  adc_ctrl_pkg::scan_state_t state;
  logic [7:0] timer;
  logic [3:0] scan_chan;
  logic fifo_wr;
  adc_ctrl_pkg::result_t fifo_in, fifo_out;
  logic fifo_rd;
  logic sw_start, hw_start;
  assign hw_start = cnv_rise && cs_n_s && internal_clock_o; // [RULE18]
  assign sw_start = cs_rise && software_convert_trigger_o && internal_clock_o
    && (cs_low_cnt == 6'(`WRITE_MIN_CLOCKS)); // [RULE21]
  assign conv_done = (state == adc_ctrl_pkg::CONVERT) && (timer == '0) && (scan_chan == chan_sel);
  assign fifo_wr = (state == adc_ctrl_pkg::CONVERT) && (timer == '0);
  assign fifo_in.chan = scan_chan;
  assign fifo_in.code = encode(sample_i, unipolar_all);

  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset) begin
      state <= adc_ctrl_pkg::IDLE;
      timer <= '0;
      scan_chan <= '0;
    end else begin
      unique case (state)
        adc_ctrl_pkg::IDLE: begin
          scan_chan <= '0;
          if (hw_start) begin
            state <= adc_ctrl_pkg::CONVERT;
            timer <= 8'(`CONV_TIME_CYC - 1); // [RULE17]
          end else if (sw_start) begin
            state <= adc_ctrl_pkg::WAIT_DELAY;
            timer <= 8'(`SOFTWARE_CONVERT_TRIGGER_DELAY_CYC - 1);
          end
        end
        adc_ctrl_pkg::WAIT_DELAY: begin
          if (timer == '0) begin
            state <= adc_ctrl_pkg::CONVERT;
            timer <= 8'(`CONV_TIME_CYC - 1);
          end else begin
            timer <= timer - 1'b1;
          end
        end
        adc_ctrl_pkg::CONVERT: begin
          if (timer != '0) begin
            timer <= timer - 1'b1;
          end else if (conv_done) begin
            state <= adc_ctrl_pkg::DONE; // [RULE19]
          end else begin
            scan_chan <= scan_chan + 1'b1;
            timer <= 8'(`CONV_TIME_CYC - 1);
          end
        end
        adc_ctrl_pkg::DONE: begin
          state <= adc_ctrl_pkg::IDLE;
        end
      endcase
    end
  end
  assign sample_o = (state == adc_ctrl_pkg::CONVERT) && (timer == 8'(`CONV_TIME_CYC - 1));
  // the multiplexer follows the scan while converting, otherwise the requested channel
  assign mux_chan_o = (state == adc_ctrl_pkg::CONVERT) ? scan_chan : chan_sel;

  always_ff @(posedge mclk_i) begin
    if (reset_i || soft_reset) begin
      end_of_conversion_n_o <= 1'b1;
    end else if (state == adc_ctrl_pkg::DONE) begin
      end_of_conversion_n_o <= 1'b0; // [RULE19] [RULE25]
    end else if (cs_fall || cnv_fall) begin
      end_of_conversion_n_o <= 1'b1; // [RULE19]
    end
  end

  adc_result_fifo #(.DEPTH(`FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .reset_i(reset_i || soft_reset),
    .wr_i(fifo_wr),
    .wr_data_i(fifo_in),
    .rd_i(fifo_rd),
    .rd_data_o(fifo_out),
    .empty_o(fifo_empty_o)
  );

  // external clock: the channel requested last frame is sampled at select fall and sent in this frame
  adc_ctrl_pkg::result_t ext_result;
  assign ext_result.chan = chan_sel; // [RULE16]
  assign ext_result.code = encode(sample_i, unipolar_all);

  // output word load and shift
  logic [`WORD_BITS-1:0] next_word;
  always_comb begin
    if (internal_clock_o) begin
      next_word = fifo_empty_o ? '0 : {fifo_out.chan, fifo_out.code}; // [RULE14] [RULE15]
    end else if (channel_tag_enable_o) begin
      next_word = {ext_result.chan, ext_result.code}; // [RULE4]
    end else begin
      next_word = {1'b0, ext_result.code, 3'h0}; // [RULE6]
    end
  end
  assign fifo_rd = internal_clock_o && in_frame && word_done;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_shift <= '0;
    end else if (cs_fall || (word_done && in_frame)) begin
      tx_shift <= next_word; // [RULE14]
    end else if (sclk_fall && in_frame && bit_cnt != '0) begin
      tx_shift <= {tx_shift[`WORD_BITS-2:0], 1'b0}; // [RULE2]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_o <= tx_shift[`WORD_BITS-1];
      sdo_oe_o <= !cs_n_s; // [RULE24]
    end
  end
endmodule

// file: hdl/adc_ctrl_cfg.svh
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
// Behaviour
// (RULE1) master makes SCLK, at most 48 MHz, mode 3, idling high.
// (RULE2) with chip select low, input taken on SCLK rise, output changed on fall.
// (RULE3) chip select fall samples inputs, starts a frame of at least 16 bits.
// (RULE4) tag enabled: word is 4-bit channel then 12-bit result, MSB first.
// (RULE5) tag enabled: master should hold SCLK high a period before chip select falls.
// (RULE6) tag disabled (external clock only): zero, 12-bit result, three zeros.
// (RULE7) 10-bit variants force the two lowest result bits to zero.
// (RULE8) unipolar: output zero when positive input is below negative input.
// (RULE9) single-ended channels always convert unipolar, referenced to ground.
// (RULE10) pseudo-differential select: up to 15 inputs measured against the common input.
// (RULE11) unipolar results straight binary, bipolar results two's complement.
// (RULE12) a 16-entry FIFO keeps internally clocked results until read.
// (RULE13) full FIFO and new result: the oldest result is overwritten.
// (RULE14) each result is two bytes, channel ahead of MSB; oldest shown after chip select falls.
// (RULE15) empty FIFO: serial output drives zeros during a read frame.
// (RULE16) external clock: channel asked in one frame is sent out in the next frame.
// (RULE17) internal mode timed by a nominal 40 MHz oscillator, plus or minus 15 percent.
// (RULE18) master starts an internal scan with chip select high and a low start pulse.
// (RULE19) scan converts into FIFO then end-of-conversion low until chip select or start falls.
// (RULE20) master waits for end-of-conversion before chip select or another start pulse.
// (RULE21) software trigger starts conversion after chip select rise delay; cleared on completion.
// (RULE22) switching internal to external clock needs a soft reset code 10.
// (RULE23) input bit 15 zero addresses mode control, one addresses configuration.
// (RULE24) serial output is high impedance while chip select is high.
// (RULE25) internal mode data valid only after end-of-conversion goes low.
`define CLK_PERIOD_NS 100
`define WORD_BITS 16
`define RESULT_BITS 12
`define CHAN_BITS 4
`define FIFO_DEPTH 16
`define WRITE_MIN_CLOCKS 17
`define SOFTWARE_CONVERT_TRIGGER_DELAY_NS 500
`define SOFTWARE_CONVERT_TRIGGER_DELAY_CYC ((`SOFTWARE_CONVERT_TRIGGER_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 2100
`define CONV_TIME_CYC ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_SEL_BIT 15
`define CHAN_TAG_BIT 2
`define SOFTWARE_CONVERT_TRIGGER_BIT 1
`define CHSEL_HI 10
`define CHSEL_LO 7
`define SCAN_HI 14
`define SCAN_LO 11
`define CFG_ID_HI 14
`define CFG_ID_LO 11
`define CFG_ID_ADC 4'h0
`define CFG_ID_UNI 4'h1
`define CFG_ID_BIP 4'h2
`define RESET_HI 6
`define RESET_LO 5
`define SOFT_RESET 2'h2
`define PDIFF_BIT 2
`define SCAN_MANUAL 4'h1
`endif

// file: hdl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] code;
  } result_t;
  typedef struct packed {
    logic [3:0] chan;
    logic signed [12:0] diff;
    logic single_ended;
    logic bipolar;
  } sample_t;
  typedef enum logic [1:0] {
    IDLE, WAIT_DELAY, CONVERT, DONE
  } scan_state_t;
endpackage

// file: hdl/adc_sync2.sv
`timescale 1ns/1ps
module adc_sync2 (
  // clock
  input wire logic mclk_i,
  input wire logic reset_i,
  // data
  input wire logic d_i,
  output logic q_o
);
  logic stage1;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stage1 <= 1'b1;
      q_o <= 1'b1;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule

// file: hdl/adc_result_fifo.sv
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_result_fifo #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock
  input wire logic mclk_i,
  input wire logic reset_i,
  // write side
  input wire logic wr_i,
  input wire adc_ctrl_pkg::result_t wr_data_i,
  // read side
  input wire logic rd_i,
  output adc_ctrl_pkg::result_t rd_data_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  adc_ctrl_pkg::result_t mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic full;
  logic do_rd;
  assign full = (count == (AW+1)'(DEPTH));
  assign empty_o = (count == '0);
  assign do_rd = rd_i && !empty_o;
  assign rd_data_o = mem[rptr];
  always_ff @(posedge mclk_i) begin
    if (wr_i) begin
      mem[wptr] <= wr_data_i; // [RULE12]
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (wr_i) begin
        wptr <= wptr + 1'b1;
      end
      if ((wr_i && full) || do_rd) begin
        rptr <= rptr + 1'b1; // [RULE13]
      end
      if (wr_i && !full && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !wr_i) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: test/adc_ctrl_assertions.sv
`timescale 1ns/1ps
module adc_ctrl_assertions (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // watched pins
  input wire logic cs_n_i,
  input wire logic conversion_start_n_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic end_of_conversion_n_o,
  input wire logic internal_clock_o,
  input wire logic software_convert_trigger_o,
  input wire logic fifo_empty_o
);
  logic [2:0] cs_low_cnt;
  logic empty_frame;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // remembers a frame that opened on an empty fifo in internal mode
  always_ff @(posedge mclk_i) begin
    if (reset_i || cs_n_i) begin
      cs_low_cnt <= 3'h0;
      empty_frame <= 1'b0;
    end else begin
      if (cs_low_cnt == 3'h0) begin
        empty_frame <= fifo_empty_o && internal_clock_o;
      end
      if (cs_low_cnt != 3'h7) begin
        cs_low_cnt <= cs_low_cnt + 3'h1;
      end
    end
  end
  oe_released_a: assert property (cs_n_i [*5] |-> !sdo_oe_o)
    else $error("serial output driven while deselected");
  oe_driven_a: assert property (!cs_n_i [*5] |-> sdo_oe_o)
    else $error("serial output not driven in frame");
  eoc_holds_a: assert property (!end_of_conversion_n_o && cs_n_i && conversion_start_n_i |=> !end_of_conversion_n_o)
    else $error("end of conversion released early");
  eoc_cs_clear_a: assert property ($fell(cs_n_i) |-> ##[1:5] end_of_conversion_n_o)
    else $error("end of conversion kept after select");
  eoc_start_clear_a: assert property ($fell(conversion_start_n_i) |-> ##[1:5] end_of_conversion_n_o)
    else $error("end of conversion kept after start");
  empty_zero_a: assert property (empty_frame && cs_low_cnt == 3'h7 |-> !sdo_o)
    else $error("nonzero data from empty fifo");
  scan_time_a: assert property ($rose(conversion_start_n_i) && internal_clock_o |->
    end_of_conversion_n_o [*8] ##[10:400] !end_of_conversion_n_o)
    else $error("scan end timing wrong");
  software_convert_trigger_wait_a: assert property ($rose(cs_n_i) && software_convert_trigger_o |-> end_of_conversion_n_o [*8])
    else $error("software conversion ended too soon");
  software_convert_trigger_clear_a: assert property ($fell(software_convert_trigger_o) |-> ##[0:3] !end_of_conversion_n_o)
    else $error("trigger cleared without completion");
endmodule
bind adc_serial_conversion_control adc_ctrl_assertions adc_ctrl_assertions_inst (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .cs_n_i(cs_n_i),
  .conversion_start_n_i(conversion_start_n_i),
  .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o),
  .end_of_conversion_n_o(end_of_conversion_n_o),
  .internal_clock_o(internal_clock_o),
  .software_convert_trigger_o(software_convert_trigger_o),
  .fifo_empty_o(fifo_empty_o)
);

// file: test/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // received word
  output logic rx_valid_o,
  output logic [15:0] rx_word_o
);
  logic last_bit;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_word_o = 16'h0000;
    last_bit = 1'b0;
  end
  // one mode 3 frame of 16 bits at 800 ns per bit
  task automatic xfer(input logic [15:0] tx);
    logic [15:0] rx;
    rx = 16'h0000;
    #1637; // clock idles high well before select falls
    cs_n_o = 1'b0;
    #400;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      sdi_o = tx[i];
      #400;
      sclk_o = 1'b1;
      // a released output reads back as the inverse of its last level
      rx[i] = sdo_oe_i ? sdo_i : ~last_bit;
      last_bit = rx[i];
      #400;
    end
    #800;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    rx_word_o = rx;
    rx_valid_o = 1'b1;
    #100;
    rx_valid_o = 1'b0;
  endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_i, reset_i, conversion_start_n_i, sclk, cs_n, sdi, sdo_o, sdo_oe_o, eoc_n, sample_o, int_clk, tag_en;
  logic sw_trig, pdiff, fifo_empty, rx_valid, prev_t;
  logic [3:0] mux_chan_o, prev_c;
  logic [15:0] rx_word;
  logic [16:0] e;
  logic [31:0] r;
  logic [16:0] expq [$];
  adc_ctrl_pkg::sample_t sample_i;
  adc_ctrl_pkg::sample_t tab [16];
  int n_errors, total_checks, seed;
  adc_serial_conversion_control adc_serial_conversion_control_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .conversion_start_n_i(conversion_start_n_i), .end_of_conversion_n_o(eoc_n), .sample_i(sample_i),
    .mux_chan_o(mux_chan_o), .sample_o(sample_o), .internal_clock_o(int_clk), .channel_tag_enable_o(tag_en),
    .software_convert_trigger_o(sw_trig), .pseudo_diff_common_select_o(pdiff), .fifo_empty_o(fifo_empty));
  spi_master_model spi_master_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_o),
    .sdo_oe_i(sdo_oe_o), .rx_valid_o(rx_valid), .rx_word_o(rx_word));
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // analog front end answers for the selected channel
  always @(negedge mclk_i) sample_i <= tab[mux_chan_o];
  function automatic logic [11:0] code_of(input logic [3:0] c);
    if ((tab[c].single_ended || !tab[c].bipolar) && tab[c].diff < 0) return 12'h000;
    return tab[c].diff[11:0];
  endfunction
  function automatic logic [15:0] word_of(input logic [3:0] c, input logic t);
    return t ? {c, code_of(c)} : {1'b0, code_of(c), 3'h0};
  endfunction
  function automatic logic [15:0] mode(input logic [3:0] scan, input logic [3:0] c, input logic t, input logic sw);
    return {1'b0, scan, c, 4'h0, t, sw, 1'b0};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic send(input logic [15:0] w, input logic chk, input logic [15:0] x);
    expq.push_back({chk, x});
    @(negedge mclk_i);
    spi_master_model_inst.xfer(w);
  endtask
  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_n !== 1'b0 && n < 600) begin
      @(negedge mclk_i);
      n++;
    end
    check({15'h0, eoc_n}, 16'h0000, "end of conversion");
  endtask
  task automatic pulse_start();
    @(negedge mclk_i);
    conversion_start_n_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    conversion_start_n_i = 1'b1;
    wait_eoc();
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge rx_valid) begin
    e = expq.pop_front();
    if (e[16]) check(rx_word, e[15:0], "serial word");
  end
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'h8DCA;
    n_errors = 0;
    total_checks = 0;
    reset_i = 1'b1;
    conversion_start_n_i = 1'b1;
    sample_i = '0;
    prev_c = 4'h0;
    prev_t = 1'b1;
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      tab[c].chan = c[3:0];
      tab[c].single_ended = r[14];
      tab[c].bipolar = r[15];
      tab[c].diff = (r[15] && !r[14]) ? {r[11], r[11:0]} : {r[16], r[11:0]};
    end
    repeat (20) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    // manual frames, tag on then off, each answering the previous request
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      send(mode(4'h1, r[3:0], k < 6, 1'b0), k > 0, word_of(prev_c, prev_t));
      prev_c = r[3:0];
      prev_t = (k < 6);
      check({12'h0, mux_chan_o}, {12'h0, prev_c}, "channel");
      check({14'h0, tag_en, int_clk}, {14'h0, prev_t, 1'b0}, "tag and clock mode");
    end
    send(16'h8804, 1'b1, word_of(prev_c, prev_t));
    check({15'h0, pdiff}, 16'h0001, "pseudo differential");
    send(16'h8800, 1'b0, 16'h0000);
    check({15'h0, pdiff}, 16'h0000, "pseudo differential");
    // internal scans: sixteen results, one read, three more of which two overwrite the oldest
    send(mode(4'h3, 4'hF, 1'b1, 1'b0), 1'b0, 16'h0000);
    check({15'h0, int_clk}, 16'h0001, "internal clock");
    pulse_start();
    check({15'h0, fifo_empty}, 16'h0000, "fifo filled");
    send(mode(4'h3, 4'h2, 1'b1, 1'b0), 1'b1, word_of(4'h0, 1'b1));
    pulse_start();
    for (int k = 3; k < 19; k++) send(16'h8800, 1'b1, word_of(k[3:0], 1'b1));
    check({15'h0, fifo_empty}, 16'h0001, "fifo drained");
    send(mode(4'h3, 4'h0, 1'b1, 1'b1), 1'b1, 16'h0000);
    check({15'h0, sw_trig}, 16'h0001, "software trigger set");
    wait_eoc();
    check({15'h0, sw_trig}, 16'h0000, "software trigger cleared");
    send(16'h8800, 1'b1, word_of(4'h0, 1'b1));
    send(16'h8040, 1'b1, 16'h0000);
    check({14'h0, tag_en, int_clk}, 16'h0000, "after soft reset");
    @(negedge mclk_i);
    wrap_up();
  end
endmodule
